//--- src/floppy_drive_control_regs.sv
// floppy drive control registers: status b, drive output control, tape assign
//
// How it works
// - full status view: status b bits 6 and 7 always read one
// - latched view: status b bits 0 and 1 always read one
// - latched view: bit 2 set on write gate rise, cleared by input reg read
// - latched view: bit 3 set on read data fall, cleared by input reg read
// - latched view: bit 4 set on write data fall, not gated by write gate
// - latched view: bits 5,6 show select outputs, bit 7 reads one
// - drive output control untouched by soft reset, writable any time
// - output bits 1:0 are a binary drive number, one select at most
// - output bit 2 low holds controller reset, other bits untouched
// - soft reset lasts at least 100 ns, clear-then-set writes suffice
// - non-full views: bit 3 enables dma and irq pins, else float/ignore
// - full view: dma and irq pins always enabled, reset clears bit 3
// - bits 4,5 drive motors 0,1; bits 6,7 read zero
// - tape bits 1:0 pick tape drive 1..3 or none, never drive 0
// - normal tape view: only bits 1:0, upper bits float; no soft reset
// - normal decode: drive 0/1 with its motor bit selects 0/1 low
// - swapped decode exchanges selects and motor outputs of drives 0,1
// - enhanced mode 2: tape reg shows type id, boot drive, tape bits
// - type id is the drive type config pair chosen by drive number
// - plain view: status b read floats the data bus
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ns
`include "floppy_ctrl_consts.svh"

module floppy_drive_control_regs
  import floppy_ctrl_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              clock,
  input  wire logic              sys_rst,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic [7:0]             rd_lane_oe,
  // disk interface signals from the controller core
  input  wire logic              write_gate,
  input  wire logic              read_data,
  input  wire logic              write_data,
  input  wire logic              second_drive_present_n,
  input  wire logic              swap_drives,
  // dma and interrupt pins
  input  wire logic              core_drq,
  input  wire logic              floppy_irq,
  input  wire logic              dma_ack_n,
  input  wire logic              dma_tc,
  output dma_pins_s              dma_pins,
  // drive interface and core controls
  output drive_pins_s            drive_pins,
  output logic                   soft_reset_n,
  output logic                   dma_pin_enable,
  output logic                   tape_access,
  output logic [1:0]             drive_type_id
);

  // ---------------------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------------------
  logic [7:0]  doc_ff;
  logic [1:0]  tape_ff;
  logic [7:0]  mode_ff;
  logic [7:0]  dtype_ff;
  logic        swap_ff;
  logic [2:0]  sync1_ff;
  logic [2:0]  sync2_ff;
  logic [2:0]  prev_ff;
  logic [2:0]  latch_ff;
  logic [1:0]  toggle_ff;
  logic [3:0]  rst_cnt_ff;
  logic        soft_reset_n_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic [7:0]  lane_oe_ff;
  drive_pins_s drive_ff;
  dma_pins_s   dma_ff;
  logic        dma_en_ff;
  logic        tape_access_ff;
  logic [1:0]  dtype_id_ff;

  localparam logic [3:0] RST_CYC = 4'(`SOFT_RST_CYC);

  // ---------------------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------------------
  logic [ADDR_W-3:0] idx;
  logic              access;
  logic              done;
  logic              wr_en;
  logic              dir_read;
  logic              hit;
  view_mode_e        view;
  logic [1:0]        drive_num;
  logic              enh2;
  logic [1:0]        boot_drive;
  logic [1:0]        type_pair;
  logic [2:0]        rise;
  logic [2:0]        fall;
  logic [2:0]        set_ev;
  logic              nxt_sel0_n;
  logic              nxt_sel1_n;

  assign idx        = paddr[ADDR_W-1:2];
  assign access     = psel && penable && !pready_ff;
  // writes and read side effects land on the edge that completes the transfer
  assign done       = psel && penable && pready_ff;
  assign wr_en      = done && pwrite && pstrb[0];
  assign dir_read   = done && !pwrite && (idx == 10'(`IDX_DIGITAL_INPUT));
  assign hit        = (idx == 10'(`IDX_LATCHED_STATUS_B)) ||
                      (idx == 10'(`IDX_DRIVE_OUTPUT_CTRL)) ||
                      (idx == 10'(`IDX_TAPE_ASSIGN)) ||
                      (idx == 10'(`IDX_DIGITAL_INPUT)) ||
                      (idx == 10'(`IDX_MODE_CFG)) ||
                      (idx == 10'(`IDX_DRIVE_TYPE_CFG));
  // code 3 of the view field is not a mode; it behaves as the plain view
  assign view       = (mode_ff[`MODE_VIEW_LSB +: 2] == 2'h1) ? VIEW_FULL :
                      (mode_ff[`MODE_VIEW_LSB +: 2] == 2'h2) ? VIEW_LATCHED : VIEW_PLAIN;
  assign enh2       = mode_ff[`MODE_ENH2_BIT];
  assign boot_drive = mode_ff[`MODE_BOOT_LSB +: 2];
  assign drive_num  = doc_ff[`DOC_DRIVE_LSB +: 2];
  assign type_pair  = dtype_ff[{drive_num, 1'b0} +: 2];

  // ---------------------------------------------------------------------------
  // drive select decode, normal or swapped
  // ---------------------------------------------------------------------------
  // only drives 0 and 1 exist; numbers 2 and 3 leave both selects off
  always_comb begin
    nxt_sel0_n = 1'b1;
    nxt_sel1_n = 1'b1;
    case (drive_num)
      2'h0: begin
        if (swap_ff) nxt_sel1_n = !doc_ff[`DOC_MOTOR0_BIT];
        else         nxt_sel0_n = !doc_ff[`DOC_MOTOR0_BIT];
      end
      2'h1: begin
        if (swap_ff) nxt_sel0_n = !doc_ff[`DOC_MOTOR1_BIT];
        else         nxt_sel1_n = !doc_ff[`DOC_MOTOR1_BIT];
      end
      default: begin
        nxt_sel0_n = 1'b1;
        nxt_sel1_n = 1'b1;
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // software-visible registers
  // ---------------------------------------------------------------------------
  // only hardware reset touches this one; the soft reset bit never clears it
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      doc_ff <= `DOC_RESET_VAL;
    end else if (wr_en && idx == 10'(`IDX_DRIVE_OUTPUT_CTRL)) begin
      doc_ff <= pwdata[7:0] & `DOC_WRITE_MASK;
    end
  end

  // tape assignment survives soft reset
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tape_ff <= `TAPE_RESET_VAL;
    end else if (wr_en && idx == 10'(`IDX_TAPE_ASSIGN)) begin
      tape_ff <= pwdata[1:0];
    end
  end

  // view mode, enhanced mode and boot drive configuration
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mode_ff <= `MODE_RESET_VAL;
    end else if (wr_en && idx == 10'(`IDX_MODE_CFG)) begin
      mode_ff <= pwdata[7:0];
    end
  end

  // drive type pairs, one per drive number
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      dtype_ff <= `DRIVE_TYPE_RESET_VAL;
    end else if (wr_en && idx == 10'(`IDX_DRIVE_TYPE_CFG)) begin
      dtype_ff <= pwdata[7:0];
    end
  end

  // decode choice comes from outside; hardware reset forces normal
  always_ff @(posedge clock) begin
    if (sys_rst) swap_ff <= 1'b0;
    else         swap_ff <= swap_drives;
  end

  // ---------------------------------------------------------------------------
  // latched disk interface events
  // ---------------------------------------------------------------------------
  // bit 0 write gate (rising), bit 1 read data (falling), bit 2 write data (falling)
  assign rise = sync2_ff & ~prev_ff;
  assign fall = ~sync2_ff & prev_ff;
  assign set_ev = {fall[2], fall[1], rise[0]};

  // two-flop synchronisers; the first stage feeds only the second
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
      prev_ff  <= 3'h0;
    end else begin
      sync1_ff <= {write_data, read_data, write_gate};
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff;
    end
  end

  // per-bit sticky latches; an edge in the clearing cycle still sets the bit
  for (genvar b = 0; b < 3; b++) begin : g_latch
    always_ff @(posedge clock) begin
      if (sys_rst)        latch_ff[b] <= 1'b0;
      else if (set_ev[b]) latch_ff[b] <= 1'b1;
      else if (dir_read)  latch_ff[b] <= 1'b0;
    end
  end

  // data toggles shown in the full status view
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      toggle_ff <= 2'h0;
    end else begin
      if (fall[1]) toggle_ff[0] <= !toggle_ff[0];
      if (fall[2]) toggle_ff[1] <= !toggle_ff[1];
    end
  end

  // ---------------------------------------------------------------------------
  // soft reset with a guaranteed least width
  // ---------------------------------------------------------------------------
  // the counter reloads while the bit is low, so even a clear directly
  // followed by a set write gives a full-width pulse
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rst_cnt_ff      <= RST_CYC;
      soft_reset_n_ff <= 1'b0;
    end else if (!doc_ff[`DOC_RESET_N_BIT]) begin
      rst_cnt_ff      <= RST_CYC;
      soft_reset_n_ff <= 1'b0;
    end else if (rst_cnt_ff != 4'h0) begin
      rst_cnt_ff      <= rst_cnt_ff - 4'h1;
      soft_reset_n_ff <= 1'b0;
    end else begin
      soft_reset_n_ff <= 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // pin outputs
  // ---------------------------------------------------------------------------
  // motor outputs swap along with the selects
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      drive_ff <= '1;
    end else begin
      drive_ff.sel0_n <= nxt_sel0_n;
      drive_ff.sel1_n <= nxt_sel1_n;
      if (swap_ff) begin
        drive_ff.motor1_n <= !doc_ff[`DOC_MOTOR0_BIT];
        drive_ff.motor0_n <= !doc_ff[`DOC_MOTOR1_BIT];
      end else begin
        drive_ff.motor0_n <= !doc_ff[`DOC_MOTOR0_BIT];
        drive_ff.motor1_n <= !doc_ff[`DOC_MOTOR1_BIT];
      end
    end
  end

  // pin enable: full view keeps the pins live even while reset clears bit 3
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      dma_en_ff <= 1'b0;
      dma_ff    <= '0;
    end else begin
      dma_en_ff        <= (view == VIEW_FULL) || doc_ff[`DOC_DMA_EN_BIT];
      dma_ff.drq       <= core_drq;
      dma_ff.irq       <= floppy_irq;
      dma_ff.drq_oe    <= (view == VIEW_FULL) || doc_ff[`DOC_DMA_EN_BIT];
      dma_ff.irq_oe    <= (view == VIEW_FULL) || doc_ff[`DOC_DMA_EN_BIT];
      // disabled acknowledge and terminal count read as inactive
      dma_ff.dma_ack_n <= ((view == VIEW_FULL) || doc_ff[`DOC_DMA_EN_BIT]) ? dma_ack_n : 1'b1;
      dma_ff.tc        <= ((view == VIEW_FULL) || doc_ff[`DOC_DMA_EN_BIT]) && dma_tc;
    end
  end

  // tape handling flag and current drive type for the core
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tape_access_ff <= 1'b0;
      dtype_id_ff    <= 2'h0;
    end else begin
      // code 00 means no tape, so drive 0 can never match
      tape_access_ff <= (tape_ff != 2'h0) && (tape_ff == drive_num);
      dtype_id_ff    <= type_pair;
    end
  end

  // ---------------------------------------------------------------------------
  // apb answer: one wait state, data and lane enables registered
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
      lane_oe_ff <= 8'h00;
    end else if (access) begin
      pready_ff  <= 1'b1;
      pslverr_ff <= !hit;
      prdata_ff  <= 32'h0000_0000;
      lane_oe_ff <= 8'hff;
      if (!pwrite) begin
        case (idx)
          10'(`IDX_LATCHED_STATUS_B): begin
            case (view)
              VIEW_FULL: begin
                prdata_ff[7:0] <= {2'b11, doc_ff[0], toggle_ff, sync2_ff[0],
                                   doc_ff[`DOC_MOTOR1_BIT], doc_ff[`DOC_MOTOR0_BIT]};
              end
              VIEW_LATCHED: begin
                prdata_ff[7:0] <= {second_drive_present_n | 1'b1,
                                   drive_ff.sel1_n, drive_ff.sel0_n,
                                   latch_ff, 2'b11};
              end
              default: begin
                lane_oe_ff <= 8'h00;
              end
            endcase
          end
          10'(`IDX_DRIVE_OUTPUT_CTRL): prdata_ff[7:0] <= doc_ff;
          10'(`IDX_TAPE_ASSIGN): begin
            if (enh2) begin
              prdata_ff[7:0] <= {2'b00, type_pair, boot_drive, tape_ff};
            end else begin
              prdata_ff[7:0] <= {6'h00, tape_ff};
              lane_oe_ff     <= 8'h03;
            end
          end
          10'(`IDX_MODE_CFG):       prdata_ff[7:0] <= mode_ff;
          10'(`IDX_DRIVE_TYPE_CFG): prdata_ff[7:0] <= dtype_ff;
          default:                  prdata_ff      <= 32'h0000_0000;
        endcase
      end
    end else begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end
  end

  assign prdata         = prdata_ff;
  assign pready         = pready_ff;
  assign pslverr        = pslverr_ff;
  assign rd_lane_oe     = lane_oe_ff;
  assign dma_pins       = dma_ff;
  assign drive_pins     = drive_ff;
  assign soft_reset_n   = soft_reset_n_ff;
  assign dma_pin_enable = dma_en_ff;
  assign tape_access    = tape_access_ff;
  assign drive_type_id  = dtype_id_ff;

endmodule

//--- include/floppy_ctrl_consts.svh
// constants for the floppy drive control register bank
`ifndef FLOPPY_CTRL_CONSTS_SVH
`define FLOPPY_CTRL_CONSTS_SVH

// register indexes as printed; the byte address is four times the index
`define IDX_LATCHED_STATUS_B    12'h3f1
`define IDX_DRIVE_OUTPUT_CTRL   12'h3f2
`define IDX_TAPE_ASSIGN         12'h3f3
`define IDX_DIGITAL_INPUT       12'h3f7
`define IDX_MODE_CFG            12'h040
`define IDX_DRIVE_TYPE_CFG      12'h041

// drive output control fields
`define DOC_DRIVE_LSB           0
`define DOC_RESET_N_BIT         2
`define DOC_DMA_EN_BIT          3
`define DOC_MOTOR0_BIT          4
`define DOC_MOTOR1_BIT          5
`define DOC_WRITE_MASK          8'h3f
`define DOC_RESET_VAL           8'h00

// mode configuration fields
`define MODE_VIEW_LSB           0
`define MODE_ENH2_BIT           2
`define MODE_BOOT_LSB           4
`define MODE_RESET_VAL          8'h00
`define DRIVE_TYPE_RESET_VAL    8'h00
`define TAPE_RESET_VAL          2'h0

// timing: least soft reset pulse, rounded up to whole clocks
`define CLK_MHZ                 100
`define SOFT_RST_MIN_NS         100
`define SOFT_RST_CYC            ((`SOFT_RST_MIN_NS * `CLK_MHZ + 999) / 1000)

`endif

//--- include/floppy_ctrl_pkg.sv
// types shared by the floppy drive control register bank
package floppy_ctrl_pkg;

  // how the status register b address answers
  typedef enum logic [1:0] {
    VIEW_PLAIN,
    VIEW_FULL,
    VIEW_LATCHED
  } view_mode_e;

  // drive interface outputs, all active low
  typedef struct packed {
    logic sel1_n;
    logic sel0_n;
    logic motor1_n;
    logic motor0_n;
  } drive_pins_s;

  // dma and interrupt pin group seen by the host bus
  typedef struct packed {
    logic drq;
    logic drq_oe;
    logic irq;
    logic irq_oe;
    logic dma_ack_n;
    logic tc;
  } dma_pins_s;

endpackage

//--- bench/floppy_drive_control_regs_monitor.sv
// bound checker for the floppy drive control register bank
`timescale 1ns/1ns
`include "floppy_ctrl_consts.svh"

module floppy_drive_control_regs_monitor
  import floppy_ctrl_pkg::*;
(
  input wire logic        clock,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [7:0]  rd_lane_oe,
  input wire drive_pins_s drive_pins,
  input wire logic        soft_reset_n,
  input wire logic        dma_pin_enable
);
  logic [7:0] low_cnt_ff;

  // low cycles of the controller reset; saturates so long holds never wrap
  always_ff @(posedge clock) begin
    if (sys_rst || soft_reset_n) begin
      low_cnt_ff <= 8'h00;
    end else if (low_cnt_ff != 8'hff) begin
      low_cnt_ff <= low_cnt_ff + 8'h01;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_wait_ready;
    !pready ##1 pready;
  endsequence

  wait_state_a: assert property (psel && !penable |=> s_wait_ready)
    else $error("apb answer not after one wait state");
  one_select_a: assert property (drive_pins.sel0_n || drive_pins.sel1_n)
    else $error("two drive selects active");
  sel0_motor_a: assert property (!drive_pins.sel0_n |-> !drive_pins.motor0_n)
    else $error("select 0 without its motor");
  sel1_motor_a: assert property (!drive_pins.sel1_n |-> !drive_pins.motor1_n)
    else $error("select 1 without its motor");
  softrst_len_a: assert property ($rose(soft_reset_n) |-> low_cnt_ff >= `SOFT_RST_CYC)
    else $error("controller reset too short");
  reset_state_a: assert property ($fell(sys_rst) |->
    drive_pins == 4'hf && !soft_reset_n && !dma_pin_enable)
    else $error("outputs not at reset state");
  read_width_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data above byte lane");
  float_zero_a: assert property (pready && !pwrite && rd_lane_oe == 8'h00
    |-> prdata[7:0] == 8'h00)
    else $error("floating read shows data");
  err_answer_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error without answer");
endmodule

bind floppy_drive_control_regs floppy_drive_control_regs_monitor i_mon (
  .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rd_lane_oe(rd_lane_oe), .drive_pins(drive_pins),
  .soft_reset_n(soft_reset_n), .dma_pin_enable(dma_pin_enable));

//--- bench/floppy_disk_model.sv
// behavioural disk side: write gate, read data and write data pulses
`timescale 1ns/1ns

module floppy_disk_model (
  input  wire logic clock,
  output logic      write_gate,
  output logic      read_data,
  output logic      write_data
);
  initial begin
    {write_gate, read_data, write_data} = 3'h0;
  end

  // four clock pulse; both edges land, so rising and falling latches see it
  task automatic pulse(input logic [1:0] k);
    @(posedge clock);
    case (k)
      2'h0: write_gate <= 1'b1;
      2'h1: read_data <= 1'b1;
      default: write_data <= 1'b1;
    endcase
    repeat (4) @(posedge clock);
    {write_gate, read_data, write_data} <= 3'h0;
  endtask
endmodule

//--- bench/tb_floppy_drive_control_regs.sv
// self-checking bench for the floppy drive control register bank
`timescale 1ns/1ns
`include "floppy_ctrl_consts.svh"

module tb_floppy_drive_control_regs
  import floppy_ctrl_pkg::*;
;
  localparam logic [11:0] A_SRB  = 12'(`IDX_LATCHED_STATUS_B * 4);
  localparam logic [11:0] A_DOC  = 12'(`IDX_DRIVE_OUTPUT_CTRL * 4);
  localparam logic [11:0] A_TAPE = 12'(`IDX_TAPE_ASSIGN * 4);
  localparam logic [11:0] A_DIN  = 12'(`IDX_DIGITAL_INPUT * 4);
  localparam logic [11:0] A_MODE = 12'(`IDX_MODE_CFG * 4);
  localparam logic [11:0] A_TYPE = 12'(`IDX_DRIVE_TYPE_CFG * 4);
  logic        clock, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_data;
  logic [3:0]  pstrb;
  logic [7:0]  rd_lane_oe, rd_oe;
  logic        write_gate, read_data, write_data, swap_drives, rd_err;
  logic        core_drq, floppy_irq, dma_ack_n, dma_tc;
  logic        soft_reset_n, dma_pin_enable, tape_access;
  logic [1:0]  drive_type_id;
  dma_pins_s   dma_pins;
  drive_pins_s drive_pins;
  int          fails, cmp_count;

  floppy_drive_control_regs #(.ADDR_W(12)) i_floppy_drive_control_regs (
    .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rd_lane_oe(rd_lane_oe),
    .write_gate(write_gate), .read_data(read_data), .write_data(write_data),
    .second_drive_present_n(1'b0), .swap_drives(swap_drives),
    .core_drq(core_drq), .floppy_irq(floppy_irq), .dma_ack_n(dma_ack_n),
    .dma_tc(dma_tc), .dma_pins(dma_pins), .drive_pins(drive_pins),
    .soft_reset_n(soft_reset_n), .dma_pin_enable(dma_pin_enable),
    .tape_access(tape_access), .drive_type_id(drive_type_id));

  floppy_disk_model i_floppy_disk_model (
    .clock(clock), .write_gate(write_gate), .read_data(read_data),
    .write_data(write_data));

  always #5 clock = ~clock;

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one apb transfer; the request holds until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fails++;
      conclude();
    end
    {rd_data, rd_oe, rd_err} = {prdata, rd_lane_oe, pslverr};
    {psel, penable} <= 2'b00;
  endtask

  // pins are registered, so give them a few clocks before looking
  task automatic doc_pins(input logic [7:0] v, input logic [3:0] exp);
    apb(1'b1, A_DOC, {24'h0, v});
    repeat (3) @(posedge clock);
    chk("drive pins", {28'h0, exp}, {28'h0, drive_pins});
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    apb(1'b0, A_DOC, 32'h0);
    chk("doc reset", 32'h0, rd_data);
    chk("pins reset", 32'hf, {28'h0, drive_pins});
    chk("ctl reset", 32'h0, {31'h0, soft_reset_n});
    $display("test reset done");
  endtask

  task automatic t_normal();
    doc_pins(8'h1c, 4'ha);
    doc_pins(8'h2d, 4'h5);
    chk("dma on", 32'h3d, {26'h0, dma_pins});
    doc_pins(8'h0c, 4'hf);
    // bit 3 clear here, so the pins must be released and inputs masked
    doc_pins(8'h16, 4'he);
    chk("dma off", 32'h2a, {26'h0, dma_pins});
    chk("pin en off", 32'h0, {31'h0, dma_pin_enable});
    doc_pins(8'hff, 4'hc);
    apb(1'b0, A_DOC, 32'h0);
    chk("doc top bits", 32'h3f, rd_data);
    $display("test normal decode done");
  endtask

  task automatic t_swap();
    swap_drives <= 1'b1;
    doc_pins(8'h1c, 4'h5);
    doc_pins(8'h2d, 4'ha);
    swap_drives <= 1'b0;
    $display("test swapped decode done");
  endtask

  task automatic t_softrst();
    int n;
    apb(1'b1, A_TAPE, 32'h2);
    apb(1'b1, A_DOC, 32'h18);
    apb(1'b1, A_DOC, 32'h1c);
    chk("ctl held", 32'h0, {31'h0, soft_reset_n});
    n = 0;
    while (soft_reset_n !== 1'b1 && n < 40) begin
      @(posedge clock);
      n++;
    end
    chk("ctl released", 32'h1, {31'h0, soft_reset_n});
    apb(1'b0, A_DOC, 32'h0);
    chk("doc kept", 32'h1c, rd_data);
    apb(1'b0, A_TAPE, 32'h0);
    chk("tape kept", 32'h2, rd_data);
    chk("tape lanes", 32'h3, {24'h0, rd_oe});
    $display("test soft reset done");
  endtask

  task automatic t_status();
    apb(1'b1, A_MODE, 32'h2);
    apb(1'b0, A_DIN, 32'h0);
    apb(1'b0, A_SRB, 32'h0);
    chk("latched idle", 32'hc3, rd_data);
    i_floppy_disk_model.pulse(2'h0);
    i_floppy_disk_model.pulse(2'h1);
    i_floppy_disk_model.pulse(2'h2);
    repeat (5) @(posedge clock);
    apb(1'b0, A_SRB, 32'h0);
    chk("latched set", 32'hdf, rd_data);
    apb(1'b0, A_DIN, 32'h0);
    apb(1'b0, A_SRB, 32'h0);
    chk("latched clear", 32'hc3, rd_data);
    apb(1'b1, A_MODE, 32'h1);
    // dma enable bit off: only the full view may keep the pins live
    apb(1'b1, A_DOC, 32'h14);
    apb(1'b0, A_SRB, 32'h0);
    chk("full top bits", 32'h3, {30'h0, rd_data[7:6]});
    chk("full view", 32'hd9, rd_data);
    chk("full dma", 32'h3d, {26'h0, dma_pins});
    chk("full pin en", 32'h1, {31'h0, dma_pin_enable});
    apb(1'b1, A_MODE, 32'h0);
    apb(1'b0, A_SRB, 32'h0);
    chk("plain lanes", 32'h0, {24'h0, rd_oe});
    chk("plain dma", 32'h2a, {26'h0, dma_pins});
    $display("test status views done");
  endtask

  task automatic t_tape();
    apb(1'b1, A_TYPE, 32'h1b);
    apb(1'b1, A_MODE, 32'h34);
    apb(1'b1, A_DOC, 32'h06);
    apb(1'b0, A_TAPE, 32'h0);
    chk("tape enh", 32'h1e, rd_data);
    chk("tape enh lanes", 32'hff, {24'h0, rd_oe});
    for (int d = 0; d < 4; d++) begin
      apb(1'b1, A_DOC, 32'h4 | 32'(d));
      repeat (3) @(posedge clock);
      chk("type id", 32'(3 - d), {30'h0, drive_type_id});
      chk("tape access", 32'(d == 2), {31'h0, tape_access});
    end
    apb(1'b0, 12'h200, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, rd_err});
    $display("test tape assign done");
  endtask

  initial begin
    clock = 1'b0;
    sys_rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'h1;
    {swap_drives, core_drq, floppy_irq, dma_ack_n, dma_tc} = 5'b01101;
    {fails, cmp_count} = '0;
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    t_reset();
    t_normal();
    t_swap();
    t_softrst();
    t_status();
    t_tape();
    conclude();
  end
endmodule
